/* bench/testbench.sv */
// Purpose: Self-checking bench for the pending-message line
// Assumes: Queue depth cut to 8 so a full drain stays short
// Notes: The bench samples the pending line only through its pull-up
`timescale 1ns/1ns
module testbench;
    // ****************************************
    // Signals and instances
    // ****************************************
    localparam int DEPTH = 8;
    logic clk, nrst, msg_valid, msg_ready, sda_o, sda_oe, irq_o, irq_oe;
    logic scl, host_sda, sda_line, irq_line, a;
    logic [63:0] msg_data;
    int n_mismatch, num_checks;
    assign sda_line = ~(host_sda | (sda_oe & ~sda_o));
    assign irq_line = ~(irq_oe & ~irq_o);

    tmpi_core #(.DEPTH(DEPTH)) tmpi_core_i (.clk(clk), .nrst(nrst), .scl_i(scl),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
        .message_pending_irq_n_o(irq_o), .message_pending_irq_n_oe(irq_oe),
        .msg_valid(msg_valid), .msg_ready(msg_ready), .msg_data(msg_data));
    tmpi_host_model tmpi_host_model_i (.clk(clk), .sda_line(sda_line), .scl(scl),
        .sda_drive(host_sda));

    initial clk = 1'b0;
    always #5 clk = ~clk;

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_bit(input string name, input logic exp, input logic got);
        chk_byte(name, {7'h00, exp}, {7'h00, got});
    endtask

    // Distinct bytes per position catch a swapped byte order
    function automatic logic [63:0] msg_word(input int k);
        return {8'h17, 8'(k), 32'hC3A5_5AE1, 8'h40, 8'(k + 3)};
    endfunction

    task automatic push(input logic [63:0] d);
        int i;
        msg_valid <= 1'b1;
        msg_data <= d;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (msg_ready === 1'b1) break;
        end
        msg_valid <= 1'b0;
        @(posedge clk);
        if (i == 20) begin
            n_mismatch++;
            $display("ERROR push expected accept seen timeout");
            results();
        end
    endtask

    task automatic set_ptr();
        tmpi_host_model_i.start_cond();
        tmpi_host_model_i.send_byte({tmpi_pkg::TARGET_ADDR, 1'b0}, a);
        chk_bit("write address ack", 1'b1, a);
        tmpi_host_model_i.send_byte(tmpi_pkg::MSG_COUNT_ADDR[7:0], a);
        chk_bit("pointer low ack", 1'b1, a);
        tmpi_host_model_i.send_byte(tmpi_pkg::MSG_COUNT_ADDR[15:8], a);
        chk_bit("pointer high ack", 1'b1, a);
        tmpi_host_model_i.stop_cond();
    endtask

    // Reads count, then n messages; optionally one more id, then NACK and STOP
    task automatic read_run(input int k0, input int cnt, input int n, input logic end_ff);
        logic [7:0] b;
        logic [63:0] w;
        tmpi_host_model_i.start_cond();
        tmpi_host_model_i.send_byte({tmpi_pkg::TARGET_ADDR, 1'b1}, a);
        chk_bit("read address ack", 1'b1, a);
        tmpi_host_model_i.recv_byte(1'b1, b);
        chk_byte("message count", 8'(cnt), b);
        for (int j = 0; j < n; j++) begin
            w = msg_word(k0 + j);
            for (int m = 0; m < 8; m++) begin
                tmpi_host_model_i.recv_byte((m < 7) || (j < n - 1) || end_ff, b);
                chk_byte("message byte", w[8*m +: 8], b);
                if (j == 0 && m == 0) chk_bit("line after id", 1'b1, irq_line);
            end
        end
        if (end_ff) begin
            tmpi_host_model_i.recv_byte(1'b0, b);
            chk_byte("invalid id", 8'hFF, b);
        end
        tmpi_host_model_i.stop_cond();
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_idle();
        repeat (20) @(posedge clk);
        chk_bit("line after reset", 1'b1, irq_line);
        chk_bit("ready after reset", 1'b1, msg_ready);
    endtask

    task automatic t_single();
        push(msg_word(0));
        repeat (3) @(posedge clk);
        chk_bit("line on message", 1'b0, irq_line);
        set_ptr();
        chk_bit("line while pending", 1'b0, irq_line);
        read_run(0, 1, 1, 1'b0);
        chk_bit("line after last stop", 1'b1, irq_line);
    endtask

    task automatic t_two();
        push(msg_word(1));
        push(msg_word(2));
        repeat (3) @(posedge clk);
        chk_bit("line on new message", 1'b0, irq_line);
        read_run(1, 2, 1, 1'b0);
        chk_bit("line with one left", 1'b0, irq_line);
        read_run(2, 1, 1, 1'b1);
        chk_bit("line when empty", 1'b1, irq_line);
    endtask

    // Push DEPTH messages to fill the queue, push into the full queue, then drain in one read
    task automatic t_fill();
        for (int i = 0; i < DEPTH; i++) push(msg_word(3 + i));
        repeat (2) @(posedge clk);
        chk_bit("ready when full", 1'b0, msg_ready);
        msg_valid <= 1'b1;
        msg_data <= msg_word(90);
        repeat (3) @(posedge clk);
        msg_valid <= 1'b0;
        read_run(3, DEPTH, DEPTH, 1'b1);
        chk_bit("line after drain", 1'b1, irq_line);
        chk_bit("ready after drain", 1'b1, msg_ready);
    endtask

    task automatic t_badaddr();
        tmpi_host_model_i.start_cond();
        tmpi_host_model_i.send_byte({tmpi_pkg::TARGET_ADDR ^ 7'h01, 1'b1}, a);
        chk_bit("foreign address ack", 1'b0, a);
        tmpi_host_model_i.stop_cond();
        chk_bit("line stays released", 1'b1, irq_line);
    endtask

    initial begin
        nrst = 1'b0;
        msg_valid = 1'b0;
        msg_data = 64'h0;
        n_mismatch = 0;
        num_checks = 0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (5) @(posedge clk);
        t_idle();
        t_single();
        t_two();
        t_fill();
        t_badaddr();
        results();
    end
endmodule // testbench

/* bench/tmpi_host_model.sv */
// Purpose: Host side of the I2C port, master only, open-drain on SDA
// Assumes: Caller starts each task just after a rising clock edge
// Notes: SCL is push-pull since the target never stretches it
`timescale 1ns/1ns
module tmpi_host_model #(
    parameter int HALF = 8
) (
    input wire logic clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_drive
);
    // ****************************************
    // Bus primitives
    // ****************************************
    // No port reaches the pending line: the host leaves it to its pull-up
    initial begin
        scl = 1'b1;
        sda_drive = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic start_cond();
        sda_drive <= 1'b1;
        tick(HALF);
        scl <= 1'b0;
        tick(HALF);
    endtask

    // Final byte of a read or write is done, then STOP ends the transfer
    task automatic stop_cond();
        sda_drive <= 1'b1;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        sda_drive <= 1'b0;
        tick(2 * HALF);
    endtask

    // SDA only moves with SCL low, sampled at the end of the high phase
    task automatic bit_cycle(input logic b, output logic seen);
        sda_drive <= ~b;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        seen = sda_line;
        scl <= 1'b0;
        tick(HALF);
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cycle(b[i], s);
        bit_cycle(1'b1, s);
        ack = ~s;
    endtask

    task automatic recv_byte(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, s);
            b[i] = s;
        end
        bit_cycle(~ack, s);
    endtask
endmodule // tmpi_host_model

/* src/tmpi_core.sv */
// Purpose: I2C target serving touch messages, with the pending-message line
// Assumes: SCL and SDA are asynchronous pins; no clock stretching
// Notes: Writes set the address pointer only; bytes after the second overwrite its high byte
`timescale 1ns/1ns
module tmpi_core #(
    parameter int DEPTH = tmpi_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic message_pending_irq_n_o,
    output logic message_pending_irq_n_oe,
    input wire logic msg_valid,
    output logic msg_ready,
    input wire logic [tmpi_pkg::MSG_WIDTH-1:0] msg_data
);
    localparam int CW = $clog2(DEPTH+1);

    initial begin
        if (DEPTH > 255) begin
            $error("tmpi_core message count must fit in one byte");
        end
    end

    // ****************************************
    // Pin synchronisers and bus conditions
    // ****************************************
    logic [1:0] scl_sync_q;
    logic [1:0] sda_sync_q;
    logic scl_prev_q;
    logic sda_prev_q;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_sync_q <= {scl_sync_q[0], scl_i};
            sda_sync_q <= {sda_sync_q[0], sda_i};
            scl_prev_q <= scl_sync_q[1];
            sda_prev_q <= sda_sync_q[1];
        end
    end

    wire scl_s = scl_sync_q[1];
    wire sda_s = sda_sync_q[1];
    wire scl_rise = scl_s && !scl_prev_q;
    wire scl_fall = !scl_s && scl_prev_q;
    wire start_w = scl_s && scl_prev_q && sda_prev_q && !sda_s;
    wire stop_w = scl_s && scl_prev_q && !sda_prev_q && sda_s;

    // ****************************************
    // Message queue
    // ****************************************
    logic fifo_valid;
    logic fifo_pop;
    logic [tmpi_pkg::MSG_WIDTH-1:0] fifo_head;
    logic [CW-1:0] fifo_count;

    tmpi_fifo #(
        .WIDTH(tmpi_pkg::MSG_WIDTH),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk(clk),
        .nrst(nrst),
        .in_valid(msg_valid),
        .in_ready(msg_ready),
        .in_data(msg_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_head),
        .count(fifo_count)
    );

    // ****************************************
    // Target state and read data path
    // ****************************************
    tmpi_pkg::tmpi_state_type state_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    logic [7:0] tx_q;
    logic rw_q;
    logic wr_idx_q;
    logic [15:0] base_q;
    logic [15:0] ptr_q;
    logic [tmpi_pkg::MSG_WIDTH-1:0] cur_q;
    logic cur_real_q;
    logic hold_q;
    logic sda_oe_q;
    logic irq_oe_q;
    logic irq_o_q;
    logic sda_o_q;

    // Byte served at a pointer; the report identifier comes straight from the queue head
    function automatic logic [7:0] byte_at(input logic [15:0] p,
                                           input logic [tmpi_pkg::MSG_WIDTH-1:0] cur,
                                           input logic head_ok,
                                           input logic [7:0] head_id,
                                           input logic [CW-1:0] cnt);
        logic [15:0] off;
        off = p - tmpi_pkg::MSG_PROC_ADDR;
        if (p == tmpi_pkg::MSG_COUNT_ADDR) begin
            byte_at = 8'(cnt);
        end else if (off == 16'h0000) begin
            byte_at = head_ok ? head_id : tmpi_pkg::INVALID_REPORT_ID;
        end else if (off < 16'(tmpi_pkg::MSG_BYTES)) begin
            byte_at = cur[off[2:0]*8 +: 8];
        end else begin
            byte_at = tmpi_pkg::IDLE_BYTE;
        end
    endfunction

    wire in_msg = (ptr_q >= tmpi_pkg::MSG_PROC_ADDR) &&
                  (ptr_q <= tmpi_pkg::MSG_PROC_ADDR + 16'(tmpi_pkg::MSG_LAST_IDX));
    // Continuous reads wrap from the last message byte back to the next report identifier
    wire [15:0] ptr_next = (ptr_q == tmpi_pkg::MSG_PROC_ADDR + 16'(tmpi_pkg::MSG_LAST_IDX)) ?
                           tmpi_pkg::MSG_PROC_ADDR : ptr_q + 16'h0001;
    wire addr_match = (sh_q[7:1] == tmpi_pkg::TARGET_ADDR);
    wire ack_rise = (state_q == tmpi_pkg::TMPI_READ) && scl_rise && (cnt_q == tmpi_pkg::ACK_BIT_CNT);
    wire host_ack = ack_rise && !sda_s;
    wire host_nack = ack_rise && sda_s;
    wire id_acked = host_ack && (ptr_q == tmpi_pkg::MSG_PROC_ADDR);
    wire stage_ptr_valid = (state_q == tmpi_pkg::TMPI_ADDR) ? 1'b1 : 1'b0;
    wire [15:0] stage_ptr = stage_ptr_valid ? base_q : ptr_next;
    wire stage_now = (scl_fall && state_q == tmpi_pkg::TMPI_ADDR &&
                      cnt_q == tmpi_pkg::ACK_BIT_CNT && addr_match && sh_q[0]) || host_ack;
    wire [7:0] stage_byte = byte_at(stage_ptr, cur_q, fifo_valid, fifo_head[7:0], fifo_count);
    // The SCL fall right after START also sees a zero count; only the fall that ends
    // the address ACK still has SDA driven, so that marks the start of the data phase
    wire addr_acked = (state_q == tmpi_pkg::TMPI_ADDR) && (cnt_q == tmpi_pkg::RESET_BIT_CNT) &&
                      sda_oe_q;

    // Pop only once the host has taken the identifier, so a NACK on it loses nothing
    assign fifo_pop = id_acked && cur_real_q;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_q <= tmpi_pkg::TMPI_IDLE;
            cnt_q <= tmpi_pkg::RESET_BIT_CNT;
            sh_q <= 8'h00;
            tx_q <= 8'h00;
            rw_q <= 1'b0;
            wr_idx_q <= 1'b0;
            base_q <= tmpi_pkg::MSG_COUNT_ADDR;
            ptr_q <= tmpi_pkg::MSG_COUNT_ADDR;
            sda_oe_q <= 1'b0;
        end else if (start_w || stop_w) begin
            state_q <= start_w ? tmpi_pkg::TMPI_ADDR : tmpi_pkg::TMPI_IDLE;
            cnt_q <= tmpi_pkg::RESET_BIT_CNT;
            wr_idx_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (state_q != tmpi_pkg::TMPI_IDLE) begin
            if (scl_rise) begin
                cnt_q <= (cnt_q == tmpi_pkg::ACK_BIT_CNT) ? tmpi_pkg::RESET_BIT_CNT : cnt_q + 4'h1;
                if (cnt_q != tmpi_pkg::ACK_BIT_CNT) begin
                    sh_q <= {sh_q[6:0], sda_s};
                end
            end
            if (stage_now) begin
                tx_q <= stage_byte;
                ptr_q <= stage_ptr;
            end
            if (host_nack) begin
                state_q <= tmpi_pkg::TMPI_IDLE;
                if (in_msg) begin
                    base_q <= tmpi_pkg::MSG_COUNT_ADDR;
                end
            end
            if (scl_fall) begin
                if (cnt_q == tmpi_pkg::ACK_BIT_CNT && state_q != tmpi_pkg::TMPI_READ) begin
                    // Acknowledge address or written byte
                    sda_oe_q <= (state_q == tmpi_pkg::TMPI_WRITE) || addr_match;
                    if (state_q == tmpi_pkg::TMPI_ADDR) begin
                        rw_q <= sh_q[0];
                        state_q <= addr_match ? tmpi_pkg::TMPI_ADDR : tmpi_pkg::TMPI_IDLE;
                    end else if (!wr_idx_q) begin
                        base_q[7:0] <= sh_q;
                        wr_idx_q <= 1'b1;
                    end else begin
                        base_q[15:8] <= sh_q;
                    end
                end else if (cnt_q == tmpi_pkg::ACK_BIT_CNT) begin
                    sda_oe_q <= 1'b0;
                end else if (addr_acked) begin
                    state_q <= rw_q ? tmpi_pkg::TMPI_READ : tmpi_pkg::TMPI_WRITE;
                    sda_oe_q <= rw_q && !tx_q[7];
                end else if (state_q == tmpi_pkg::TMPI_READ) begin
                    sda_oe_q <= !tx_q[3'(4'h7 - cnt_q)];
                end else begin
                    sda_oe_q <= 1'b0;
                end
            end
        end
    end

    // ****************************************
    // Current message and pending line
    // ****************************************
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cur_q <= '0;
            cur_real_q <= 1'b0;
        end else if (stage_now && stage_ptr == tmpi_pkg::MSG_PROC_ADDR) begin
            // An empty queue serves an all-zero body behind the invalid identifier
            cur_q <= fifo_valid ? fifo_head : tmpi_pkg::MSG_WIDTH'(tmpi_pkg::INVALID_REPORT_ID);
            cur_real_q <= fifo_valid;
        end
    end

    // Level-sensitive by design: the line simply follows "queue not empty" outside the hold
    always_ff @(posedge clk) begin
        if (!nrst) begin
            hold_q <= 1'b0;
            irq_oe_q <= 1'b0;
            irq_o_q <= 1'b0;
            sda_o_q <= 1'b0;
        end else begin
            if (stop_w) begin
                hold_q <= 1'b0;
            end else if (id_acked && cur_real_q) begin
                hold_q <= 1'b1;
            end
            irq_oe_q <= fifo_valid && !hold_q;
            irq_o_q <= 1'b0;
            sda_o_q <= 1'b0;
        end
    end

    assign sda_o = sda_o_q;
    assign sda_oe = sda_oe_q;
    assign message_pending_irq_n_o = irq_o_q;
    assign message_pending_irq_n_oe = irq_oe_q;

    // ****************************************
    // Assertions
    // ****************************************
    a_line_follows_queue: assert property (@(posedge clk) disable iff (!nrst)
        (msg_valid && msg_ready && !hold_q && !id_acked) |=> ##1 message_pending_irq_n_oe)
        else $error("pending line not driven after a new message");
    a_id_release: assert property (@(posedge clk) disable iff (!nrst)
        (id_acked && cur_real_q && !stop_w) |=> ##1 !message_pending_irq_n_oe)
        else $error("pending line not released after identifier ack");
    a_stop_reassert: assert property (@(posedge clk) disable iff (!nrst)
        (stop_w ##1 fifo_valid) |=> message_pending_irq_n_oe)
        else $error("pending line not low again after stop");
    a_stop_quiet: assert property (@(posedge clk) disable iff (!nrst)
        (stop_w ##1 !fifo_valid) |=> !message_pending_irq_n_oe)
        else $error("pending line low after stop with empty queue");
    a_reset_released: assert property (@(posedge clk)
        !nrst |=> !message_pending_irq_n_oe)
        else $error("pending line driven after reset");
    a_invalid_report: assert property (@(posedge clk) disable iff (!nrst)
        (stage_now && stage_ptr == tmpi_pkg::MSG_PROC_ADDR && !fifo_valid && !start_w && !stop_w)
        |=> tx_q == tmpi_pkg::INVALID_REPORT_ID)
        else $error("empty queue did not give invalid identifier");
    a_addr_ignore: assert property (@(posedge clk) disable iff (!nrst)
        (scl_fall && state_q == tmpi_pkg::TMPI_ADDR && cnt_q == tmpi_pkg::ACK_BIT_CNT &&
         !addr_match && !start_w && !stop_w) |=> !sda_oe ##1 state_q == tmpi_pkg::TMPI_IDLE)
        else $error("foreign address acknowledged");
    a_nack_rewind: assert property (@(posedge clk) disable iff (!nrst)
        (host_nack && in_msg && !start_w && !stop_w) |=> base_q == tmpi_pkg::MSG_COUNT_ADDR)
        else $error("pointer not rewound to message count");
    a_flags_byte: assert property (@(posedge clk) disable iff (!nrst)
        (host_ack && ptr_q == tmpi_pkg::MSG_PROC_ADDR && !start_w && !stop_w)
        |=> tx_q == $past(cur_q[tmpi_pkg::FLAGS_BYTE*8 +: 8]))
        else $error("flags byte not staged after identifier");
endmodule // tmpi_core

/* src/tmpi_fifo.sv */
// Purpose: Message queue between the touch engine and the I2C port
// Assumes: Same clock on both sides
// Notes: Ready on the filling side comes from a flip-flop
`timescale 1ns/1ns
module tmpi_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH+1)-1:0] count
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("tmpi_fifo depth must be a power of two, at least 2");
        end
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic ready_q;
    wire push = in_valid && ready_q;
    wire pop = out_ready && (cnt_q != '0);

    assign cnt_d = cnt_q + CW'(push) - CW'(pop);
    assign in_ready = ready_q;
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign count = cnt_q;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            ready_q <= 1'b0;
        end else begin
            wr_q <= wr_q + AW'(push);
            rd_q <= rd_q + AW'(pop);
            cnt_q <= cnt_d;
            ready_q <= (cnt_d != CW'(DEPTH));
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule // tmpi_fifo

/* src/tmpi_pkg.sv */
// Purpose: Shared constants of the message-pending notification block
// Assumes: 100 MHz core clock, I2C target with 16-bit address pointer
// Notes: Each message is eight bytes, report identifier in the low byte
package tmpi_pkg;
    // ****************************************
    // Target address and object locations
    // ****************************************
    localparam logic [6:0] TARGET_ADDR = 7'h4B;
    localparam logic [15:0] MSG_COUNT_ADDR = 16'h012E;
    localparam logic [15:0] MSG_PROC_ADDR = 16'h012F;
    localparam logic [2:0] MSG_LAST_IDX = 3'h7;
    localparam int MSG_BYTES = 8;
    localparam int MSG_WIDTH = 64;
    localparam int FIFO_DEPTH = 32;
    // ****************************************
    // Field values
    // ****************************************
    localparam logic [7:0] INVALID_REPORT_ID = 8'hFF;
    localparam logic [7:0] IDLE_BYTE = 8'h00;
    localparam int FLAGS_BYTE = 1;
    localparam int TOUCH_DOWN_FLAG_BIT = 6;
    localparam logic [3:0] ACK_BIT_CNT = 4'h8;
    localparam logic [3:0] RESET_BIT_CNT = 4'h0;

    typedef enum logic [1:0] {
        TMPI_IDLE,
        TMPI_ADDR,
        TMPI_WRITE,
        TMPI_READ
    } tmpi_state_type;
endpackage
